// File: pss_pkg.sv
// Package for the pipelined synchronous 16K x 4 static memory
package pss_pkg;
  localparam int PSS_DEPTH     = 16384;
  localparam int PSS_ADDR_W    = 14;
  localparam int PSS_DATA_W    = 4;
  localparam int PSS_CYCLE_NS  = 7;
  localparam logic PSS_DESEL   = 1'b1;
  localparam logic PSS_READ    = 1'b1;

  typedef enum logic {
    PSS_NON_TRANSPARENT,
    PSS_WRITE_THROUGH
  } pss_mode_t;

  typedef struct packed {
    logic                  sel_b;
    logic                  wr_b;
    logic [PSS_ADDR_W-1:0] addr;
    logic [PSS_DATA_W-1:0] wdata;
  } pss_req_t;

  typedef struct packed {
    logic                  sel_b;
    logic                  wr_b;
    logic [PSS_DATA_W-1:0] data;
  } pss_pipe_t;
endpackage

// File: pss_sram.sv
// Pipelined synchronous static memory with registered outputs
`timescale 1ns/1ns
module pss_sram #(
  parameter pss_pkg::pss_mode_t MODE = pss_pkg::PSS_NON_TRANSPARENT
) (
  input  wire logic                           ref_clk,
  input  wire logic                           rst_b,
  input  wire pss_pkg::pss_req_t              req,
  input  wire logic                           out_en_b,
  output logic [pss_pkg::PSS_DATA_W-1:0]      dout,
  output logic [pss_pkg::PSS_DATA_W-1:0]      dout_oe
);
  import pss_pkg::*;

  // Storage has no reset, like a real array
  logic [PSS_DATA_W-1:0] mem [PSS_DEPTH];
  pss_req_t  req_ff;
  pss_pipe_t pipe_ff;
  pss_req_t  nxt_req;
  pss_pipe_t nxt_pipe;
  logic      drive_ff;
  logic      nxt_drive;
  logic [PSS_DATA_W-1:0] nxt_dout;

  // The address must reach every word, and no word twice
  if (PSS_DEPTH != (1 << PSS_ADDR_W)) begin : g_bad_depth
    $error("memory depth does not match address width");
  end
  if (MODE != PSS_NON_TRANSPARENT && MODE != PSS_WRITE_THROUGH) begin : g_bad_mode
    $error("unsupported write mode");
  end

  // Selected write: select and strobe both low at the sampling edge
  function automatic logic sel_write(input pss_req_t r);
    return (r.sel_b != PSS_DESEL) && (r.wr_b != PSS_READ);
  endfunction

  // Selected read: select low, strobe high at the sampling edge
  function automatic logic sel_read(input pss_req_t r);
    return (r.sel_b != PSS_DESEL) && (r.wr_b == PSS_READ);
  endfunction

  // Input stage loads every edge whatever the select
  always_comb begin
    nxt_req = req;
  end

  // Second stage: read or write-through data, with pipelined control
  always_comb begin
    nxt_pipe.sel_b = req_ff.sel_b;
    nxt_pipe.wr_b  = req_ff.wr_b;
    if (req_ff.wr_b == PSS_READ) begin
      nxt_pipe.data = mem[req_ff.addr];
    end else begin
      nxt_pipe.data = req_ff.wdata;
    end
  end

  // Output drive decision; out_en_b is combined after the drive register, without a clock
  always_comb begin
    if (pipe_ff.sel_b == PSS_DESEL) begin
      nxt_drive = 1'b0;
    end else if (pipe_ff.wr_b != PSS_READ) begin
      nxt_drive = (MODE == PSS_WRITE_THROUGH);
    end else begin
      nxt_drive = 1'b1;
    end
    nxt_dout = pipe_ff.data;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_ff   <= '{sel_b: PSS_DESEL, wr_b: PSS_READ, default: '0};
      pipe_ff  <= '{sel_b: PSS_DESEL, wr_b: PSS_READ, default: '0};
      drive_ff <= 1'b0;
      dout     <= '0;
    end else begin
      req_ff   <= nxt_req;
      pipe_ff  <= nxt_pipe;
      drive_ff <= nxt_drive;
      dout     <= nxt_dout;
    end
  end

  // Memory write; selected write commits the sampled data
  always_ff @(posedge ref_clk) begin
    if (sel_write(req_ff)) begin
      mem[req_ff.addr] <= req_ff.wdata;
    end
  end

  // Asynchronous enable gating is the one path not from a flop
  always_comb begin
    dout_oe = {PSS_DATA_W{drive_ff & ~out_en_b}};
  end

  // Slot kinds as they sit in the input register
  sequence s_rd_slot;
    sel_read(req_ff);
  endsequence

  sequence s_wr_slot;
    sel_write(req_ff);
  endsequence

  sequence s_desel_slot;
    req_ff.sel_b == PSS_DESEL;
  endsequence

  // A deselected slot floats the pins two edges on
  property p_desel_float;
    @(posedge ref_clk) disable iff (!rst_b)
    s_desel_slot |->
    ##2 dout_oe == '0;
  endproperty
  AST_DESEL_FLOAT: assert property (p_desel_float)
    else $error("deselected cycle drove outputs");

  // Enable high floats at once
  property p_oe_float;
    @(posedge ref_clk) disable iff (!rst_b)
    out_en_b |->
    dout_oe == '0;
  endproperty
  AST_OE_FLOAT: assert property (p_oe_float)
    else $error("outputs driven with enable high");

  // Non-transparent writes never reach the pins
  property p_wr_nt;
    @(posedge ref_clk) disable iff (!rst_b)
    (MODE == PSS_NON_TRANSPARENT) ##0 s_wr_slot |->
    ##2 dout_oe == '0;
  endproperty
  AST_WR_NT: assert property (p_wr_nt)
    else $error("non-transparent write drove outputs");

  // Write-through shows the written word
  property p_wr_thru;
    @(posedge ref_clk) disable iff (!rst_b)
    (MODE == PSS_WRITE_THROUGH) ##0 s_wr_slot ##2 !out_en_b |->
    dout == $past(req_ff.wdata, 2);
  endproperty
  AST_WR_THRU: assert property (p_wr_thru)
    else $error("write-through data wrong");

  // A selected read drives when enabled
  property p_read_drive;
    @(posedge ref_clk) disable iff (!rst_b)
    s_rd_slot ##2 !out_en_b |->
    dout_oe != '0;
  endproperty
  AST_READ_DRIVE: assert property (p_read_drive)
    else $error("read not driven");

  // The edge that leaves reset loads reset values, so skip it
  property p_load;
    @(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |->
    req_ff == $past(req);
  endproperty
  AST_LOAD: assert property (p_load)
    else $error("input register missed load");

  // Back-to-back write then read of one word returns the new word
  property p_raw;
    @(posedge ref_clk) disable iff (!rst_b)
    s_wr_slot ##1 (sel_read(req_ff) && req_ff.addr == $past(req_ff.addr))
    ##2 1'b1 |-> dout == $past(req_ff.wdata, 3);
  endproperty
  AST_RAW: assert property (p_raw)
    else $error("read after write returned stale data");

  // A selected read slot stays selected one stage on
  property p_lat;
    @(posedge ref_clk) disable iff (!rst_b)
    s_rd_slot |=>
    pipe_ff.sel_b != PSS_DESEL;
  endproperty
  AST_LAT: assert property (p_lat)
    else $error("pipeline control misaligned");

  // Control moves one stage each edge
  property p_pipe_ctrl;
    @(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |->
    pipe_ff.sel_b == $past(req_ff.sel_b) && pipe_ff.wr_b == $past(req_ff.wr_b);
  endproperty
  AST_PIPE_CTRL: assert property (p_pipe_ctrl)
    else $error("pipelined control lost");

  // The write word enters the second stage
  property p_wt_data;
    @(posedge ref_clk) disable iff (!rst_b)
    s_wr_slot |=>
    pipe_ff.data == $past(req_ff.wdata);
  endproperty
  AST_WT_DATA: assert property (p_wt_data)
    else $error("write word not staged");

  // Output register follows the second stage
  property p_dout_pipe;
    @(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |->
    dout == $past(pipe_ff.data);
  endproperty
  AST_DOUT_PIPE: assert property (p_dout_pipe)
    else $error("output register missed load");

  // Reads arm the driver
  property p_drive_rd;
    @(posedge ref_clk) disable iff (!rst_b)
    s_rd_slot |->
    ##2 drive_ff;
  endproperty
  AST_DRIVE_RD: assert property (p_drive_rd)
    else $error("read did not arm driver");

  // Deselected slots disarm the driver
  property p_drive_desel;
    @(posedge ref_clk) disable iff (!rst_b)
    s_desel_slot |->
    ##2 !drive_ff;
  endproperty
  AST_DRIVE_DESEL: assert property (p_drive_desel)
    else $error("deselect armed driver");

  // Writes arm the driver only in write-through
  property p_wr_drive_mode;
    @(posedge ref_clk) disable iff (!rst_b)
    s_wr_slot |->
    ##2 drive_ff == (MODE == PSS_WRITE_THROUGH);
  endproperty
  AST_WR_DRIVE_MODE: assert property (p_wr_drive_mode)
    else $error("write drive wrong for mode");

  // The address just captured must not enable the pins
  property p_no_cur_drive;
    @(posedge ref_clk) disable iff (!rst_b)
    (pipe_ff.sel_b == PSS_DESEL && req_ff.sel_b != PSS_DESEL) |=>
    !drive_ff;
  endproperty
  AST_NO_CUR_DRIVE: assert property (p_no_cur_drive)
    else $error("current cycle enabled outputs");

  // Deselect travels down the pipe
  property p_desel_pipe;
    @(posedge ref_clk) disable iff (!rst_b)
    s_desel_slot |=>
    pipe_ff.sel_b == PSS_DESEL;
  endproperty
  AST_DESEL_PIPE: assert property (p_desel_pipe)
    else $error("deselect lost in pipe");

  // Read strobe travels down the pipe
  property p_rd_pipe;
    @(posedge ref_clk) disable iff (!rst_b)
    s_rd_slot |=>
    pipe_ff.wr_b == PSS_READ;
  endproperty
  AST_RD_PIPE: assert property (p_rd_pipe)
    else $error("read strobe lost in pipe");

  // Write strobe travels down the pipe
  property p_wr_pipe;
    @(posedge ref_clk) disable iff (!rst_b)
    s_wr_slot |=>
    pipe_ff.wr_b != PSS_READ;
  endproperty
  AST_WR_PIPE: assert property (p_wr_pipe)
    else $error("write strobe lost in pipe");

  // Armed and enabled drives every bit
  property p_oe_on;
    @(posedge ref_clk) disable iff (!rst_b)
    (drive_ff && !out_en_b) |->
    dout_oe == '1;
  endproperty
  AST_OE_ON: assert property (p_oe_on)
    else $error("armed outputs not driven");

  // Enable rising floats with no clock delay
  property p_oe_rise;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(out_en_b) |->
    dout_oe == '0;
  endproperty
  AST_OE_RISE: assert property (p_oe_rise)
    else $error("enable release did not float");

  // Write-through drives every bit after a write
  property p_wt_drive;
    @(posedge ref_clk) disable iff (!rst_b)
    (MODE == PSS_WRITE_THROUGH) ##0 s_wr_slot ##2 !out_en_b |->
    dout_oe == '1;
  endproperty
  AST_WT_DRIVE: assert property (p_wt_drive)
    else $error("write-through not driven");

  // A selected write stays selected one stage on
  property p_wr_lat;
    @(posedge ref_clk) disable iff (!rst_b)
    s_wr_slot |=>
    pipe_ff.sel_b != PSS_DESEL;
  endproperty
  AST_WR_LAT: assert property (p_wr_lat)
    else $error("write select misaligned");
endmodule

// File: pss_master.sv
// Bus master model that drives the memory request port
`timescale 1ns/1ns
module pss_master (
  input  wire logic         ref_clk,
  output pss_pkg::pss_req_t req,
  output logic              out_en_b
);
  import pss_pkg::*;
  initial begin
    req = '{PSS_DESEL, PSS_READ, '0, '0};
    out_en_b = 1'b1;
  end
  // Idle slots invert old address and data so stale values never match
  task automatic issue(input logic s, w, input logic [13:0] a,
                       input logic [3:0] d, input logic oe);
    @(posedge ref_clk);
    req.sel_b <= s;
    req.wr_b  <= w;
    req.addr  <= s ? ~req.addr : a;
    req.wdata <= s ? ~req.wdata : d;
    out_en_b  <= oe;
  endtask
endmodule

// File: pss_sram_test.sv
// Self-checking bench for the pipelined 16K x 4 memory
`timescale 1ns/1ns
module pss_sram_test;
  import pss_pkg::*;
  logic           ref_clk = 1'b0;
  logic           rst_b = 1'b0;
  pss_req_t       req;
  logic           out_en_b;
  logic [3:0]     dout, dout_oe, dwt, dwt_oe;
  logic [3:0]     mem [int];
  logic [5:0]     pipe [$];
  int             error_cnt = 0;
  int             tests_run = 0;
  initial forever #4 ref_clk = ~ref_clk;
  pss_master u_master (.ref_clk(ref_clk), .req(req), .out_en_b(out_en_b));
  pss_sram u_pss_sram (.ref_clk(ref_clk), .rst_b(rst_b), .req(req),
    .out_en_b(out_en_b), .dout(dout), .dout_oe(dout_oe));
  pss_sram #(.MODE(PSS_WRITE_THROUGH)) u_pss_sram_wt (.ref_clk(ref_clk),
    .rst_b(rst_b), .req(req), .out_en_b(out_en_b), .dout(dwt),
    .dout_oe(dwt_oe));
  task automatic chk(input logic [3:0] g, e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Output of a slot shows three edges after it is driven
  task automatic step(input logic s, w, input logic [13:0] a,
                      input logic [3:0] d, input logic oe);
    logic [5:0] p;
    if (!s && !w) mem[a] = d;
    pipe.push_back({s, w, (!s && w) ? mem[a] : d});
    u_master.issue(s, w, a, d, oe);
    #1;
    if (pipe.size() > 3) begin
      p = pipe.pop_front();
      chk(dout_oe, (!p[5] && p[4] && !oe) ? 4'hf : 4'h0);
      chk(dwt_oe, (!p[5] && !oe) ? 4'hf : 4'h0);
      if (!p[5] && !oe) chk(dwt, p[3:0]);
      if (!p[5] && p[4] && !oe) chk(dout, p[3:0]);
    end
  endtask
  task automatic t_stream;
    step(0, 0, 14'h0000, 4'h5, 0);
    step(0, 0, 14'h3fff, 4'ha, 0);
    step(0, 1, 14'h0000, 4'h0, 0);
    step(0, 1, 14'h3fff, 4'h0, 0);
    step(0, 0, 14'h3fff, 4'h3, 0);
    step(0, 1, 14'h3fff, 4'h0, 0);
    for (int i = 0; i < 3; i++) step(1, 1, 14'h0, 4'h0, 0);
    $display("t_stream done");
  endtask
  task automatic t_float;
    step(0, 0, 14'h1555, 4'hc, 0);
    step(1, 0, 14'h1555, 4'h0, 0);
    for (int i = 0; i < 7; i++)
      step(i > 3, 1, 14'h1555, 4'h0, i == 3 || i == 5);
    $display("t_float done");
  endtask
  // Mid-run reset: pins float at once, storage survives
  task automatic t_reset;
    @(posedge ref_clk);
    rst_b <= 1'b0;
    #1;
    chk(dout_oe, 4'h0);
    chk(dwt_oe, 4'h0);
    pipe.delete();
    @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 3; i++) step(0, 1, 14'h1555, 4'h0, 0);
    for (int i = 0; i < 3; i++) step(1, 1, 14'h0, 4'h0, 0);
    $display("t_reset done");
  endtask
  task automatic summarize;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // About 26 cycles of traffic after 20 in reset; the limit leaves wide margin
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_stream();
    t_float();
    t_reset();
    summarize();
  end
endmodule
